// *** common/clkgen_smbus_pkg.sv ***
// shared constants and types for the clock generator control-byte slave
package clkgen_smbus_pkg;

  // ----------------------------------------------------------------------
  // bus addressing and command format
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR7      = 7'h69;  // upper seven bits of D2h
  localparam int         CMD_SINGLE_BIT   = 7;      // command bit 7: 1 = single byte
  localparam logic [3:0] BYTE_BITS        = 4'h8;   // bits in one byte
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;  // answer for indices not held here

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [6:0] IDX_SPREAD_STRAP = 7'h00;  // spread_and_strap_status
  localparam logic [6:0] IDX_OUT_EN_WAKE  = 7'h01;  // output_enable_and_wake_ctrl
  localparam logic [6:0] IDX_BLOCK_COUNT  = 7'h08;  // block_read_count

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int B0_SPREAD  = 5;  // spread enable
  localparam int B0_SATA    = 4;  // latched serial ata select
  localparam int B1_DISPLAY = 7;  // display clock output enable
  localparam int B1_SATA    = 6;  // serial ata output enable
  localparam int B1_DEBUG   = 5;  // debug cpu output enable
  localparam int B1_LANE_B  = 4;  // pcie lane b output enable
  localparam int B1_LANE_A  = 3;  // pcie lane a output enable
  localparam int B1_WAKE    = 1;  // wake-on-lan keep-alive enable

  // ----------------------------------------------------------------------
  // values after reset and writable masks
  // ----------------------------------------------------------------------
  localparam logic       RST_SPREAD      = 1'b0;   // spread off
  localparam logic [7:0] RST_BYTE1       = 8'hFE;  // all enables and wake on
  localparam logic [7:0] RST_BLOCK_COUNT = 8'h0F;  // block read count of 15
  localparam logic [7:0] B1_WR_MASK      = 8'hFA;  // bits 7:3 and 1 writable

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT
  } bus_state_t;

  typedef enum logic [1:0] {K_ADDR, K_CMD, K_CNT, K_DATA} byte_kind_t;

  typedef struct packed {
    logic serial_ata_freq_strap;  // sata select strap
    logic cpu_freq_strap_c;       // cpu select strap c
    logic cpu_freq_strap_b;       // cpu select strap b
    logic cpu_freq_strap_a;       // cpu select strap a
  } strap_t;

  typedef struct packed {
    logic start;     // start or repeated start seen
    logic stop;      // stop seen
    logic scl_rise;  // clock line rose
    logic scl_fall;  // clock line fell
    logic sda;       // data line level
  } line_ev_t;

endpackage

// *** verilog/bus_line_events.sv ***
// start, stop and clock-edge detection on the two serial lines
`timescale 1ns/1ps
module bus_line_events
  import clkgen_smbus_pkg::*;
(
  input  wire logic     sys_clk_i,  // system clock
  input  wire logic     reset_n_i,  // synchronous reset, active low
  input  wire logic     scl_i,      // serial clock line
  input  wire logic     sda_i,      // serial data line
  output line_ev_t      ev_o        // registered line events
);

  // ----------------------------------------------------------------------
  // previous line levels
  // ----------------------------------------------------------------------
  logic scl_q;  // clock level one cycle ago
  logic sda_q;  // data level one cycle ago

  // idle bus is high on both lines
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  // data moving while clock stays high marks start or stop
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ev_o <= '{start: 1'b0, stop: 1'b0, scl_rise: 1'b0, scl_fall: 1'b0, sda: 1'b1};
    end else begin
      ev_o.start    <= scl_q && scl_i && sda_q && !sda_i;
      ev_o.stop     <= scl_q && scl_i && !sda_q && sda_i;
      ev_o.scl_rise <= !scl_q && scl_i;
      ev_o.scl_fall <= scl_q && !scl_i;
      ev_o.sda      <= sda_i;
    end
  end

endmodule

// *** verilog/strap_latch.sv ***
// one-shot capture of the frequency straps on the power-good strobe
`timescale 1ns/1ps
module strap_latch
  import clkgen_smbus_pkg::*;
(
  input  wire logic   sys_clk_i,    // system clock
  input  wire logic   reset_n_i,    // synchronous reset, active low
  input  wire logic   strobe_i,     // power_good_strobe level
  input  wire logic   test_mode_i,  // allows re-sampling
  input  strap_t      straps_i,     // strap pin levels
  output logic        latched_o,    // straps have been captured
  output strap_t      straps_o      // captured strap values
);

  // ----------------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------------
  // first high strobe captures; later edges ignored unless in test mode
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      latched_o <= 1'b0;
      straps_o  <= '0;
    end else if (strobe_i && (!latched_o || test_mode_i)) begin  // R21
      latched_o <= 1'b1;
      straps_o  <= straps_i;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_straps_frozen: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R21
    latched_o && !test_mode_i |=> $stable(straps_o))
    else $error("straps changed after capture");

endmodule

// *** verilog/clkgen_ctrl_slave.sv ***
// serial control slave with wake, spread, strap and output enable bytes
//
// Contract
// R1: reference clock runs on suspend power unless wake cleared
// R2: wake cleared turns stop pin into power-down
// R3: wake enable comes up set
// R4: first power-up enables reference clock by default
// R5: all registers load defaults at reset
// R6: host changes registers only at initialisation
// R7: byte write, byte read, block write, block read
// R8: block transfers walk up, msb first
// R9: answer only address D2h
// R10: command bit 7 selects block or single
// R11: command bits 6:0 give single index
// R12: block write carries count then data bytes
// R13: block read returns count byte first
// R14: host acks block bytes, nacks last
// R15: single write changes only indexed byte
// R16: single read sends one byte, host nacks
// R17: byte 0 bit 5 enables down-spread
// R18: byte 0 strap bits show latched straps
// R19: byte 1 bits 7:3 gate outputs
// R20: wake cleared also stops oscillator in suspend
// R21: straps latched once on power-good strobe
// R22: block read count defaults to 15
// R23: reserved bits read reset values, ignore writes
`timescale 1ns/1ps
module clkgen_ctrl_slave
  import clkgen_smbus_pkg::*;
(
  input  wire logic   sys_clk_i,             // system clock, 200 MHz
  input  wire logic   reset_n_i,             // synchronous reset, active low
  input  wire logic   scl_i,                 // serial clock from host
  input  wire logic   sda_i,                 // serial data line level
  output logic        sda_o,                 // data drive level, always low
  output logic        sda_oe_o,              // high while pulling data low
  input  wire logic   suspend_pwr_i,         // suspend supply present
  input  wire logic   main_pwr_i,            // other supplies present
  input  wire logic   power_good_strobe_i,   // shared strobe / stop / power-down pin
  input  wire logic   test_mode_i,           // allows strap re-sampling
  input  strap_t      straps_i,              // strap pins
  output strap_t      freq_sel_o,            // latched strap values
  output logic        ref_clk_run_o,         // 25 MHz reference runs
  output logic        xtal_osc_run_o,        // crystal oscillator powered
  output logic        outputs_stop_o,        // stop all but reference
  output logic        power_down_o,          // whole device powered down
  output logic        spread_en_o,           // down-spread on cpu/src/pci
  output logic        display_clk_out_en_o,  // display clock enable
  output logic        serial_ata_out_en_o,   // serial ata clock enable
  output logic        debug_cpu_out_en_o,    // debug cpu clock enable
  output logic        pcie_lane_b_out_en_o,  // pcie lane b enable
  output logic        pcie_lane_a_out_en_o   // pcie lane a enable
);

  // ----------------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------------
  line_ev_t ev;           // line events, one cycle behind the pins
  logic     latched;      // straps captured
  strap_t   straps_q;     // captured straps

  bus_line_events u_events (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .ev_o      (ev)
  );

  strap_latch u_straps (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .strobe_i    (power_good_strobe_i),
    .test_mode_i (test_mode_i),
    .straps_i    (straps_i),
    .latched_o   (latched),
    .straps_o    (straps_q)
  );

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic       spread_q;     // byte 0 bit 5
  logic [7:0] byte1_q;      // byte 1 as stored
  logic [7:0] blk_cnt_q;    // block read count
  logic       wake_en;      // wake_lan_keepalive_en

  assign wake_en = byte1_q[B1_WAKE];

  // read view of one register byte
  function automatic logic [7:0] reg_rd(input logic [6:0] idx);
    if (idx == IDX_SPREAD_STRAP) begin
      reg_rd = {2'b00, spread_q, straps_q.serial_ata_freq_strap, 1'b0,  // R18
                straps_q.cpu_freq_strap_c, straps_q.cpu_freq_strap_b,
                straps_q.cpu_freq_strap_a};
    end else if (idx == IDX_OUT_EN_WAKE) begin
      reg_rd = byte1_q;
    end else if (idx == IDX_BLOCK_COUNT) begin
      reg_rd = blk_cnt_q;
    end else begin
      reg_rd = UNMAPPED_READ;
    end
  endfunction

  // ----------------------------------------------------------------------
  // transfer state
  // ----------------------------------------------------------------------
  bus_state_t st_q;         // bit-level phase
  byte_kind_t kind_q;       // meaning of the byte being received
  logic [3:0] cnt_q;        // bits moved in this byte
  logic [7:0] rx_q;         // received byte, msb first
  logic [7:0] tx_q;         // byte being sent
  logic [6:0] idx_q;        // register index
  logic       rd_q;         // read direction
  logic       block_q;      // block transfer
  logic       single_done_q;// single write already used
  logic       cnt_sent_q;   // block read count already sent
  logic       acked_q;      // host acked the last sent byte
  logic       byte_done;    // received byte ends now
  logic       ack;          // answer for the received byte
  logic       wr_en;        // register write strobe
  logic [7:0] tx_next;      // next byte to send

  assign byte_done = (st_q == ST_RX) && ev.scl_fall && (cnt_q == BYTE_BITS);
  assign wr_en     = byte_done && (kind_q == K_DATA) && ack;

  // acknowledge decision and next byte to send
  always_comb begin
    case (kind_q)
      K_ADDR:  ack = (rx_q[7:1] == SLAVE_ADDR7);  // R9
      K_DATA:  ack = !single_done_q;              // R15
      default: ack = 1'b1;                        // R12
    endcase
    tx_next = (block_q && !cnt_sent_q) ? blk_cnt_q : reg_rd(idx_q);  // R13
  end

  // ----------------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------------
  // stop ends everything; start or repeated start expects an address
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_q          <= ST_IDLE;
      kind_q        <= K_ADDR;
      cnt_q         <= '0;
      rx_q          <= '0;
      tx_q          <= '0;
      idx_q         <= '0;
      rd_q          <= 1'b0;
      block_q       <= 1'b0;
      single_done_q <= 1'b0;
      cnt_sent_q    <= 1'b0;
      acked_q       <= 1'b0;
      sda_oe_o      <= 1'b0;
    end else if (ev.stop) begin
      st_q     <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (ev.start) begin
      st_q     <= ST_RX;
      kind_q   <= K_ADDR;
      cnt_q    <= '0;
      sda_oe_o <= 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (ev.scl_rise && (cnt_q != BYTE_BITS)) begin
            rx_q  <= {rx_q[6:0], ev.sda};  // R8
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            st_q     <= ack ? ST_RX_ACK : ST_WAIT;
            sda_oe_o <= ack;
            case (kind_q)
              K_ADDR: begin
                rd_q       <= rx_q[0];
                cnt_sent_q <= 1'b0;
                kind_q     <= K_CMD;
              end
              K_CMD: begin
                block_q       <= !rx_q[CMD_SINGLE_BIT];  // R10
                idx_q         <= rx_q[CMD_SINGLE_BIT] ? rx_q[6:0] : '0;  // R11
                single_done_q <= 1'b0;
                kind_q        <= rx_q[CMD_SINGLE_BIT] ? K_DATA : K_CNT;
              end
              K_CNT: begin
                kind_q <= K_DATA;  // R12
              end
              default: begin
                if (block_q) begin
                  idx_q <= idx_q + 7'h01;  // R8
                end else begin
                  single_done_q <= 1'b1;  // R15
                end
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (ev.scl_fall) begin
            cnt_q <= rd_q ? 4'h1 : 4'h0;
            if (rd_q) begin
              st_q       <= ST_TX;  // R7
              tx_q       <= tx_next;
              sda_oe_o   <= !tx_next[7];
              cnt_sent_q <= 1'b1;
              if (block_q && cnt_sent_q) begin
                idx_q <= idx_q + 7'h01;
              end
            end else begin
              st_q     <= ST_RX;
              sda_oe_o <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (ev.scl_fall) begin
            if (cnt_q != BYTE_BITS) begin
              sda_oe_o <= !tx_q[3'd7 - cnt_q[2:0]];  // R8
              cnt_q    <= cnt_q + 4'h1;
            end else begin
              sda_oe_o <= 1'b0;
              st_q     <= ST_TX_ACK;
            end
          end
        end
        ST_TX_ACK: begin
          if (ev.scl_rise) begin
            acked_q <= !ev.sda;
          end else if (ev.scl_fall) begin
            if (acked_q) begin
              st_q       <= ST_TX;  // R14
              tx_q       <= tx_next;
              sda_oe_o   <= !tx_next[7];
              cnt_q      <= 4'h1;
              cnt_sent_q <= 1'b1;
              if (block_q && cnt_sent_q) begin
                idx_q <= idx_q + 7'h01;
              end
            end else begin
              st_q <= ST_WAIT;  // R16
            end
          end
        end
        default: begin
          sda_oe_o <= 1'b0;  // idle or ignored until next start
        end
      endcase
    end
  end

  // data line is only ever pulled low
  always_ff @(posedge sys_clk_i) begin
    sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // reserved bits keep their reset values
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      spread_q  <= RST_SPREAD;       // R5
      byte1_q   <= RST_BYTE1;        // R3
      blk_cnt_q <= RST_BLOCK_COUNT;  // R22
    end else if (wr_en) begin
      if (idx_q == IDX_SPREAD_STRAP) begin
        spread_q <= rx_q[B0_SPREAD];  // R17
      end else if (idx_q == IDX_OUT_EN_WAKE) begin
        byte1_q <= (rx_q & B1_WR_MASK) | (RST_BYTE1 & ~B1_WR_MASK);  // R23
      end else if (idx_q == IDX_BLOCK_COUNT) begin
        blk_cnt_q <= rx_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock control outputs
  // ----------------------------------------------------------------------
  // shared pin acts as strobe until straps latch, then stop or power-down
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ref_clk_run_o  <= 1'b0;
      xtal_osc_run_o <= 1'b0;
      outputs_stop_o <= 1'b0;
      power_down_o   <= 1'b0;
    end else begin
      outputs_stop_o <= latched && wake_en && !power_good_strobe_i;
      power_down_o   <= latched && !wake_en && !power_good_strobe_i;  // R2
      ref_clk_run_o  <= suspend_pwr_i && (wake_en ||  // R1 R4
                        (main_pwr_i && !(latched && !power_good_strobe_i)));
      xtal_osc_run_o <= suspend_pwr_i && (wake_en ||  // R20
                        (main_pwr_i && !(latched && !power_good_strobe_i)));
    end
  end

  // enables and strap view straight from the register bits
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      spread_en_o          <= RST_SPREAD;
      display_clk_out_en_o <= RST_BYTE1[B1_DISPLAY];
      serial_ata_out_en_o  <= RST_BYTE1[B1_SATA];
      debug_cpu_out_en_o   <= RST_BYTE1[B1_DEBUG];
      pcie_lane_b_out_en_o <= RST_BYTE1[B1_LANE_B];
      pcie_lane_a_out_en_o <= RST_BYTE1[B1_LANE_A];
      freq_sel_o           <= '0;
    end else begin
      spread_en_o          <= spread_q;           // R17
      display_clk_out_en_o <= byte1_q[B1_DISPLAY];  // R19
      serial_ata_out_en_o  <= byte1_q[B1_SATA];
      debug_cpu_out_en_o   <= byte1_q[B1_DEBUG];
      pcie_lane_b_out_en_o <= byte1_q[B1_LANE_B];
      pcie_lane_a_out_en_o <= byte1_q[B1_LANE_A];
      freq_sel_o           <= straps_q;           // R18
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic exp_bit;  // bit due on the line at this falling edge
  assign exp_bit = tx_q[3'd7 - cnt_q[2:0]];

  a_wake_default: assert property (@(posedge sys_clk_i)  // R3
    $rose(reset_n_i) |-> wake_en && (blk_cnt_q == RST_BLOCK_COUNT))
    else $error("defaults not loaded");
  a_ref_keepalive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R1
    suspend_pwr_i && wake_en |=> ref_clk_run_o && xtal_osc_run_o)
    else $error("reference stopped while wake enabled");
  a_pd_mode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R2
    latched && !wake_en && !power_good_strobe_i |=> power_down_o && !outputs_stop_o)
    else $error("pin not acting as power-down");
  a_foreign_addr: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R9
    byte_done && kind_q == K_ADDR && rx_q[7:1] != SLAVE_ADDR7 |=> !sda_oe_o [*2])
    else $error("answered a foreign address");
  a_cmd_decode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R10
    byte_done && kind_q == K_CMD |=> block_q == !$past(rx_q[7]) && st_q == ST_RX_ACK)
    else $error("command type misdecoded");
  a_msb_order: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R8
    st_q == ST_TX && ev.scl_fall && !ev.stop && !ev.start && cnt_q != BYTE_BITS
    |=> sda_oe_o == !$past(exp_bit))
    else $error("transmit bit order wrong");
  a_single_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R15
    byte_done && kind_q == K_DATA && single_done_q |=> st_q == ST_WAIT && !sda_oe_o)
    else $error("second byte accepted in single write");
  a_reserved_bits: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R23
    wr_en |=> byte1_q[2] && !byte1_q[0])
    else $error("reserved bit changed");
  a_spread_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // R17
    wr_en && idx_q == IDX_SPREAD_STRAP |=> ##1 spread_en_o == $past(rx_q[B0_SPREAD], 2))
    else $error("spread bit not applied");

  c_block_write: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_en && block_q);
  c_block_read: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    st_q == ST_TX && block_q && cnt_sent_q && idx_q != '0);
  c_single_read_nack: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    st_q == ST_TX_ACK && !block_q && ev.scl_fall && !acked_q);

endmodule

// *** test/smbus_host_model.sv ***
// serial bus host model: drives the clock and pulls the data line
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic sys_clk_i,   // system clock
  input  wire logic sda_i,       // resolved data line
  output logic      scl_o,       // serial clock, idles high
  output logic      sda_pull_o   // high while pulling data low
);
  // idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // wait n edges, then step just off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // start or repeated start, from either clock level
  task automatic start();
    wt(2);
    sda_pull_o = 1'b0;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_pull_o = 1'b1;
    wt(8);
    scl_o = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    wt(2);
    sda_pull_o = 1'b1;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_pull_o = 1'b0;
    wt(8);
  endtask
  // one byte plus acknowledge slot, msb first; a 1 releases the line
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sda_pull_o = !d[i];
      wt(8);
      scl_o = 1'b1;
      wt(8);
      q[i] = sda_i;
      scl_o = 1'b0;
    end
  endtask
endmodule

// *** test/tb_clkgen_ctrl_slave.sv ***
// self-checking bench for the clock generator control slave
`timescale 1ns/1ps
module tb_clkgen_ctrl_slave
  import clkgen_smbus_pkg::*;
;
  logic   sys_clk_i = 0, reset_n_i = 0, suspend_pwr_i = 1, main_pwr_i = 0;
  logic   strobe = 0, test_mode_i = 0, scl, pull, sda_o, sda_oe_o;
  strap_t straps_i = 4'hB, freq_sel_o;
  logic   ref_clk_run_o, xtal_osc_run_o, outputs_stop_o, power_down_o, spread_en_o;
  logic   display_clk_out_en_o, serial_ata_out_en_o, debug_cpu_out_en_o;
  logic   pcie_lane_b_out_en_o, pcie_lane_a_out_en_o;
  logic   [8:0] r;
  int     bad_count = 0, compares = 0, cycles = 0;
  wire    sda_line = !pull && (!sda_oe_o || sda_o);  // pull-up, wired-and
  clkgen_ctrl_slave DUT (.sys_clk_i, .reset_n_i, .scl_i(scl), .sda_i(sda_line), .sda_o,
    .sda_oe_o, .suspend_pwr_i, .main_pwr_i, .power_good_strobe_i(strobe), .test_mode_i,
    .straps_i, .freq_sel_o, .ref_clk_run_o, .xtal_osc_run_o, .outputs_stop_o,
    .power_down_o, .spread_en_o, .display_clk_out_en_o, .serial_ata_out_en_o,
    .debug_cpu_out_en_o, .pcie_lane_b_out_en_o, .pcie_lane_a_out_en_o);
  smbus_host_model host (.sys_clk_i, .sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));
  wire [7:0] ens = {3'h0, display_clk_out_en_o, serial_ata_out_en_o, debug_cpu_out_en_o,
    pcie_lane_b_out_en_o, pcie_lane_a_out_en_o};
  always #2.5 sys_clk_i = ~sys_clk_i;
  // verdict and end of run
  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 7000 cycles needed
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: bit %b want %b", $time, g, e);
    end
  endtask
  // send a byte and expect the slave to pull the ack low
  task automatic send(input logic [7:0] d);
    host.xfer({d, 1'b1}, r);
    chk_bit(r[0], 1'b0);
  endtask
  task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d);
    host.start();
    send(8'hD2);
    send({1'b1, idx});
    send(d);
    host.stop();
  endtask
  // single read, host leaves the last byte unacknowledged
  task automatic rd_reg(input logic [6:0] idx, input logic [7:0] e);
    host.start();
    send(8'hD2);
    send({1'b1, idx});
    host.start();
    send(8'hD3);
    host.xfer(9'h1FF, r);
    chk_byte(r[8:1], e);
    host.stop();
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // defaults straight after reset, suspend supply only
  task automatic t_reset();
    chk_bit(ref_clk_run_o, 1'b1);
    chk_bit(spread_en_o, 1'b0);
    chk_byte(ens, 8'h1F);
    rd_reg(7'h01, 8'hFE);
  endtask
  // straps taken once on the strobe, later changes ignored
  task automatic t_straps();
    strobe = 1'b1;
    wt(6);
    straps_i = 4'h4;
    wt(6);
    chk_byte({4'h0, freq_sel_o}, 8'h0B);
    test_mode_i = 1'b1;
    wt(4);
    chk_byte({4'h0, freq_sel_o}, 8'h04);
    straps_i = 4'hB;
    wt(4);
    test_mode_i = 1'b0;
    rd_reg(7'h00, 8'h13);
  endtask
  // clear enables and wake; reserved bits keep their values
  task automatic t_write_one();
    wr_reg(7'h01, 8'h01);
    wt(4);
    chk_byte(ens, 8'h00);
    chk_bit(xtal_osc_run_o, 1'b0);
    rd_reg(7'h01, 8'h04);
    rd_reg(7'h00, 8'h13);
    strobe = 1'b0;
    wt(6);
    chk_bit(power_down_o, 1'b1);
    chk_bit(ref_clk_run_o, 1'b0);
    main_pwr_i = 1'b1;
    wt(4);
    chk_bit(ref_clk_run_o, 1'b0);
    strobe = 1'b1;
    wt(6);
    chk_bit(ref_clk_run_o, 1'b1);
  endtask
  // block write of bytes 0 and 1, then stop pin with wake set
  task automatic t_block_wr();
    host.start();
    send(8'hD2);
    send(8'h00);
    send(8'h02);
    send(8'h20);
    send(8'hFE);
    host.stop();
    wt(4);
    chk_bit(spread_en_o, 1'b1);
    chk_byte(ens, 8'h1F);
    strobe = 1'b0;
    wt(6);
    chk_bit(outputs_stop_o, 1'b1);
    chk_bit(ref_clk_run_o, 1'b1);
    strobe = 1'b1;
    wt(6);
  endtask
  // block read: count first, then bytes upward, last not acked
  task automatic t_block_rd();
    host.start();
    send(8'hD2);
    send(8'h00);
    host.start();
    send(8'hD3);
    host.xfer(9'h1FE, r);
    chk_byte(r[8:1], 8'h0F);
    host.xfer(9'h1FE, r);
    chk_byte(r[8:1], 8'h33);
    host.xfer(9'h1FF, r);
    chk_byte(r[8:1], 8'hFE);
    host.stop();
  endtask
  // foreign address gets no acknowledge
  task automatic t_wrong_addr();
    host.start();
    host.xfer(9'h1A9, r);
    chk_bit(r[0], 1'b1);
    host.stop();
  endtask
  // single write to the count register, surplus byte refused
  task automatic t_extra_byte();
    host.start();
    send(8'hD2);
    send(8'h88);
    send(8'h02);
    host.xfer(9'h0AB, r);
    chk_bit(r[0], 1'b1);
    host.stop();
    rd_reg(7'h08, 8'h02);
  endtask
  // main sequence
  initial begin
    wt(5);
    reset_n_i = 1'b1;
    wt(3);
    t_reset();
    t_straps();
    t_write_one();
    t_block_wr();
    t_block_rd();
    t_wrong_addr();
    t_extra_byte();
    tally_and_finish();
  end
endmodule
